// >>> shared/iowd_pkg.sv
/*
 holds register offsets, field positions, reset values and timing counts
 for the isolated output supervision block.
 assumes a 50 MHz pclk and a 32-bit apb register bus.
*/
package iowd_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] out_lo_off = 12'h000;
	localparam logic [11:0] out_hi_off = 12'h004;
	localparam logic [11:0] in_lo_off = 12'h008;
	localparam logic [11:0] in_hi_off = 12'h00c;
	localparam logic [11:0] ctrl_off = 12'h010;
	localparam logic [11:0] interval_off = 12'h014;
	localparam logic [11:0] clear_off = 12'h018;
	localparam logic [11:0] count_off = 12'h01c;
	localparam logic [11:0] safe_lo_off = 12'h020;
	localparam logic [11:0] safe_hi_off = 12'h024;
	localparam logic [11:0] card_id_off = 12'h028;
	localparam logic [11:0] irq_stat_off = 12'h02c;
	localparam logic [11:0] irq_en_off = 12'h030;
	localparam logic [11:0] irq_clr_off = 12'h034;
	localparam logic [11:0] stat_off = 12'h038;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ctrl_enable_bit = 0;
	localparam int stat_expired_bit = 0;
	localparam int stat_enable_bit = 1;
	localparam int irq_expire_bit = 0;
	localparam int irq_width = 1;
	localparam logic [31:0] clear_key = 32'h0000a5a5;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] interval_rst = 32'hffffffff;
	localparam logic [63:0] safe_rst = 64'h0000000000000000;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int clk_mhz = 50;
	localparam int tick_ns = 100;
	localparam int clk_period_ns = 1000 / clk_mhz;
	localparam int tick_cycles = tick_ns / clk_period_ns;
	localparam int tick_cnt_w = 4;
endpackage

// >>> rtl/iowd_tick.sv
/*
 holds the 100 ns tick divider for the supervision counter.
 assumes pclk at the rate set in the package; tick is a one-cycle pulse.
*/
`timescale 1ns/1ns
module iowd_tick
	import iowd_pkg::*;
(
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, low
	input wire logic run, // count while high
	output logic tick // one pulse each tick
);
	logic [tick_cnt_w-1:0] div;
	localparam logic [tick_cnt_w-1:0] div_last = tick_cnt_w'(tick_cycles - 1);

	// divider restarts when stopped so each reload gets a full first tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			div <= '0;
			tick <= 1'b0;
		end else if (div == div_last) begin
			div <= '0;
			tick <= 1'b1;
		end else begin
			div <= div + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// >>> rtl/iowd_top.sv
/*
 holds the output supervision block: 64 outputs, 64 inputs, apb registers,
 supervision timer with safe state, power-up and hot reset output loading,
 card identifier switch and one level interrupt.
 assumes an apb master on pclk, power-up states presented by the
 nonvolatile storage at power-up, and static jumper and switch levels.
*/
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns

// Overview of operation
// - expiry without clear forces safe outputs
// - safe state holds until disable then write
// - writes except irq enable/clear discarded after expiry until disabled
// - timeout is 32-bit count of 100 ns
// - hot reset keeps or restores outputs, jumper
// - power-up drives stored nonvolatile output states
// - 64 outputs, 64 inputs, outputs read back
// - card identifier switch readable by software
module iowd_top
	import iowd_pkg::*;
#(
	parameter int n_out = 64,
	parameter int n_in = 64,
	parameter int id_w = 4
)(
	input wire logic pclk, // bus clock
	input wire logic presetn, // power-up reset, low
	input wire logic hot_resetn, // hot system reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [n_out-1:0] powerup_state, // stored power-up states
	input wire logic keep_on_hot_reset, // jumper: keep outputs
	input wire logic [id_w-1:0] card_identifier_switch, // dip switch
	input wire logic [n_in-1:0] field_in, // isolated inputs
	output logic [n_out-1:0] field_out, // isolated outputs
	output logic irq // level interrupt
);
	logic [n_in-1:0] in_meta, in_sync;
	logic [id_w-1:0] id_meta, id_sync;
	logic hot_meta, hot_sync, hot_prev;
	logic jp_meta, jp_sync;
	logic loaded;
	logic [n_out-1:0] out_reg, safe_reg;
	logic enable, expired, need_write;
	logic [31:0] interval, count;
	logic tick;
	logic irq_stat, irq_en;
	logic wr, acc, hot_edge, writes_ok, clr_cmd, expire_now;
	logic addr_ok;
	logic [31:0] next_rdata;

	// ----------------------------------------------------------------
	// synchronisers for pins
	// ----------------------------------------------------------------
	// first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_meta <= '0;
			in_sync <= '0;
			id_meta <= '0;
			id_sync <= '0;
			hot_meta <= 1'b1;
			hot_sync <= 1'b1;
			hot_prev <= 1'b1;
			jp_meta <= 1'b0;
			jp_sync <= 1'b0;
		end else begin
			in_meta <= field_in;
			in_sync <= in_meta;
			id_meta <= card_identifier_switch;
			id_sync <= id_meta;
			hot_meta <= hot_resetn;
			hot_sync <= hot_meta;
			hot_prev <= hot_sync;
			jp_meta <= keep_on_hot_reset;
			jp_sync <= jp_meta;
		end
	end

	// hot reset acts as a synchronous event so the jumper can spare outputs
	assign hot_edge = hot_prev & ~hot_sync;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign writes_ok = ~expired;
	assign clr_cmd = wr & (paddr == clear_off) & (pwdata == clear_key);
	assign expire_now = enable & tick & (count == 32'h0) & ~expired;

	// ----------------------------------------------------------------
	// apb handshake
	// ----------------------------------------------------------------
	// one wait state: ready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
		end
	end

	// ----------------------------------------------------------------
	// power-up load flag
	// ----------------------------------------------------------------
	// states are caught after release, never in the reset branch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded <= 1'b0;
		end else begin
			loaded <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// output register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg <= '0;
		end else if (!loaded) begin
			out_reg <= powerup_state;
		end else if (hot_edge) begin
			if (!jp_sync) begin
				out_reg <= powerup_state;
			end
		end else if (wr && writes_ok && paddr == out_lo_off) begin
			out_reg[31:0] <= pwdata;
		end else if (wr && writes_ok && paddr == out_hi_off) begin
			out_reg[63:32] <= pwdata;
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// safe state wins while expired or until software rewrites outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			field_out <= '0;
		end else if (expired || need_write) begin
			field_out <= safe_reg;
		end else begin
			field_out <= out_reg;
		end
	end

	// ----------------------------------------------------------------
	// safe state pattern
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			safe_reg <= safe_rst;
		end else if (wr && writes_ok && paddr == safe_lo_off) begin
			safe_reg[31:0] <= pwdata;
		end else if (wr && writes_ok && paddr == safe_hi_off) begin
			safe_reg[63:32] <= pwdata;
		end
	end

	// ----------------------------------------------------------------
	// supervision control
	// ----------------------------------------------------------------
	// the enable bit can still be cleared after expiry: it is the only way out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable <= 1'b0;
			interval <= interval_rst;
		end else begin
			if (wr && paddr == ctrl_off) begin
				if (writes_ok || !pwdata[ctrl_enable_bit]) begin
					enable <= pwdata[ctrl_enable_bit];
				end
			end
			if (wr && writes_ok && paddr == interval_off) begin
				interval <= pwdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// expiry and release sequence
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			expired <= 1'b0;
			need_write <= 1'b0;
		end else if (expire_now) begin
			expired <= 1'b1;
		end else if (expired && wr && paddr == ctrl_off &&
				!pwdata[ctrl_enable_bit]) begin
			expired <= 1'b0;
			need_write <= 1'b1;
		end else if (need_write && wr &&
				(paddr == out_lo_off || paddr == out_hi_off)) begin
			need_write <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// supervision counter
	// ----------------------------------------------------------------
	// host must clear before the tick that finds the count at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= interval_rst;
		end else if (!enable) begin
			count <= interval;
		end else if (clr_cmd && writes_ok) begin
			count <= interval;
		end else if (tick && count != 32'h0) begin
			count <= count - 32'h1;
		end
	end

	iowd_tick u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.run(enable & ~expired & ~clr_cmd),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// interrupt status and enable
	// ----------------------------------------------------------------
	// a new expiry beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= 1'b0;
			irq_en <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (expire_now) begin
				irq_stat <= 1'b1;
			end else if (wr && paddr == irq_clr_off &&
					pwdata[irq_expire_bit]) begin
				irq_stat <= 1'b0;
			end
			if (wr && paddr == irq_en_off) begin
				irq_en <= pwdata[irq_expire_bit];
			end
			irq <= (irq_stat | expire_now) & irq_en;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0;
		addr_ok = 1'b1;
		case (paddr)
			out_lo_off: next_rdata = field_out[31:0];
			out_hi_off: next_rdata = field_out[63:32];
			in_lo_off: next_rdata = in_sync[31:0];
			in_hi_off: next_rdata = in_sync[63:32];
			ctrl_off: next_rdata[ctrl_enable_bit] = enable;
			interval_off: next_rdata = interval;
			clear_off: next_rdata = 32'h0;
			count_off: next_rdata = count;
			safe_lo_off: next_rdata = safe_reg[31:0];
			safe_hi_off: next_rdata = safe_reg[63:32];
			card_id_off: next_rdata[id_w-1:0] = id_sync;
			irq_stat_off: next_rdata[irq_expire_bit] = irq_stat;
			irq_en_off: next_rdata[irq_expire_bit] = irq_en;
			irq_clr_off: next_rdata = 32'h0;
			stat_off: begin
				next_rdata[stat_expired_bit] = expired;
				next_rdata[stat_enable_bit] = enable;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// read data and error
	// ----------------------------------------------------------------
	// data and error are registered in the wait cycle, valid with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			prdata <= pwrite ? 32'h0 : next_rdata;
			pslverr <= ~addr_ok;
		end else begin
			pslverr <= 1'b0;
		end
	end

endmodule

// >>> tb/iowd_assertions.sv
/* checker for the apb answer and output read-back of iowd_top.
 assumes it is bound onto iowd_top and sees its ports only. */
`timescale 1ns/1ns
module iowd_assertions
	import iowd_pkg::*;
#(parameter int n_out = 64, parameter int id_w = 4)(
	input wire logic pclk, // bus clock
	input wire logic presetn, // reset, low
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic [id_w-1:0] card_identifier_switch, // id switch
	input wire logic [n_out-1:0] field_out // outputs
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// one wait state, then a single-cycle answer
	property p_ans; $rose(psel && penable) |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("long ready");
	property p_qual; pready |-> psel && penable; endproperty
	a_qual: assert property (p_qual) else $error("stray ready");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_unmap; pready && paddr > stat_off |-> pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("no error");
	property p_map;
		pready && paddr <= stat_off && paddr[1:0] == 2'b00 |-> !pslverr;
	endproperty
	a_map: assert property (p_map) else $error("bad error");
	// switch is static, so the read must equal the pins
	property p_id;
		pready && !pwrite && paddr == card_id_off
			|-> prdata == 32'(card_identifier_switch);
	endproperty
	a_id: assert property (p_id) else $error("bad id");
	property p_lo;
		pready && !pwrite && paddr == out_lo_off
			|-> prdata == $past(field_out[31:0]);
	endproperty
	a_lo: assert property (p_lo) else $error("bad lo");
	property p_hi;
		pready && !pwrite && paddr == out_hi_off
			|-> prdata == $past(field_out[63:32]);
	endproperty
	a_hi: assert property (p_hi) else $error("bad hi");
	c_wr: cover property (pready && pwrite);
	c_rd: cover property (pready && !pwrite);
	c_err: cover property (pslverr);
endmodule
bind iowd_top iowd_assertions #(.n_out(n_out), .id_w(id_w))
	u_iowd_assertions (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .card_identifier_switch, .field_out);

// >>> tb/iowd_host.sv
/* host software model: apb master and the periodic clear command.
 assumes pclk from the bench and a slave that answers with pready. */
`timescale 1ns/1ns
module iowd_host
	import iowd_pkg::*;
(
	input wire logic pclk, // bus clock
	output logic psel, // select
	output logic penable, // enable
	output logic pwrite, // direction
	output logic [11:0] paddr, // address
	output logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr // error
);
	int hung = 0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// request held until ready is seen or 40 cycles pass; data scrambled once released
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 40);
		if (pready !== 1'b1) begin
			hung++;
			$display("unexpected at %0t: no ready", $time);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
	// software keeps control by clearing inside each interval
	task kick;
		logic [31:0] r;
		logic e;
		xfer(1'b1, clear_off, clear_key, r, e);
	endtask
endmodule

// >>> tb/iowd_top_tb.sv
/* self-checking bench for iowd_top with a host model and a checker.
 assumes the package offsets and a five-cycle tick. */
`timescale 1ns/1ns
module iowd_top_tb;
	import iowd_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic hot_resetn = 1'b1;
	logic keep_on_hot_reset = 1'b1;
	logic [3:0] card_identifier_switch = 4'h9;
	logic [63:0] powerup_state = 64'h0;
	logic [63:0] field_in = 64'h0;
	logic psel, penable, pwrite, pready, pslverr, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] lfsr_st = 32'd59;
	logic [63:0] field_out, exp_out, safe;
	int n_fail = 0;
	int samples_checked = 0;
	int i;
	initial forever #10 pclk = ~pclk;
	iowd_top u_iowd_top (.pclk, .presetn, .hot_resetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .powerup_state,
		.keep_on_hot_reset, .card_identifier_switch, .field_in, .field_out,
		.irq);
	iowd_host u_iowd_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^
			lfsr_st[1] ^ lfsr_st[0]};
		return lfsr_st;
	endfunction
	task chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task rd_chk(input logic [11:0] a, input logic [31:0] d);
		u_iowd_host.xfer(1'b0, a, 32'h0, rd, err);
		// a hung bus ends the run at once
		if (u_iowd_host.hung != 0) wrap_up;
		chk(64'({err, rd}), 64'(d));
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		u_iowd_host.xfer(1'b1, a, d, rd, err);
		if (u_iowd_host.hung != 0) wrap_up;
	endtask
	task out_chk;
		@(posedge pclk);
		#1 chk(field_out, exp_out);
	endtask
	task irq_chk(input logic v);
		repeat (2) @(posedge pclk);
		#1 chk(64'(irq), 64'(v));
	endtask
	// hot reset with the jumper given; low restores power-up states
	task hot(input logic k);
		@(posedge pclk);
		keep_on_hot_reset <= k;
		repeat (4) @(posedge pclk);
		hot_resetn <= 1'b0;
		repeat (8) @(posedge pclk);
		hot_resetn <= 1'b1;
		if (!k) exp_out = powerup_state;
		out_chk;
	endtask
	task wrap_up;
		n_fail = n_fail + u_iowd_host.hung;
		if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		powerup_state <= {rnd(), rnd()};
		field_in <= {rnd(), rnd()};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		#1 chk(field_out, powerup_state);
		rd_chk(out_hi_off, powerup_state[63:32]);
		rd_chk(in_lo_off, field_in[31:0]);
		rd_chk(in_hi_off, field_in[63:32]);
		rd_chk(card_id_off, 32'(card_identifier_switch));
		rd_chk(interval_off, interval_rst);
		u_iowd_host.xfer(1'b0, 12'h0fc, 32'h0, rd, err);
		if (u_iowd_host.hung != 0) wrap_up;
		chk(64'(err), 64'h1);
		exp_out = {rnd(), rnd()};
		wr(out_lo_off, exp_out[31:0]);
		wr(out_hi_off, exp_out[63:32]);
		out_chk;
		hot(1'b1);
		hot(1'b0);
		safe = {rnd(), rnd()};
		wr(safe_lo_off, safe[31:0]);
		wr(safe_hi_off, safe[63:32]);
		wr(interval_off, 32'd3);
		wr(ctrl_off, 32'd1);
		repeat (4) begin
			repeat (8) @(posedge pclk);
			u_iowd_host.kick;
		end
		if (u_iowd_host.hung != 0) wrap_up;
		out_chk;
		wr(irq_en_off, 32'd1);
		i = 0;
		// look after the edge so the new drive has settled
		while (field_out !== safe && i < 100) begin
			@(posedge pclk);
			#1;
			i++;
		end
		chk(64'(i >= 10 && i <= 25), 64'h1);
		if (i >= 100) wrap_up;
		rd_chk(irq_stat_off, 32'h1);
		rd_chk(stat_off, 32'h3);
		irq_chk(1'b1);
		wr(irq_en_off, 32'd0);
		irq_chk(1'b0);
		wr(irq_en_off, 32'd1);
		irq_chk(1'b1);
		// dropped write to the high word shows up in the final compare
		wr(out_hi_off, ~exp_out[63:32]);
		wr(ctrl_off, 32'd1);
		rd_chk(out_lo_off, safe[31:0]);
		wr(ctrl_off, 32'd0);
		rd_chk(stat_off, 32'h0);
		rd_chk(count_off, 32'd3);
		rd_chk(out_hi_off, safe[63:32]);
		wr(irq_clr_off, 32'd1);
		irq_chk(1'b0);
		exp_out[31:0] = rnd();
		wr(out_lo_off, exp_out[31:0]);
		out_chk;
		wrap_up;
	end
endmodule
